// ===== ewc_cpu_model.sv
// cpu core stand-in: keeps the global interrupt mask and acknowledges entries
`timescale 1ns/1ps
`default_nettype none
module ewc_cpu_model (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic int_start_in,
  input wire logic set_imask_in,
  input wire logic clear_imask_in,
  input wire logic unstack_in,
  input wire logic [1:0] ack_dly_in,
  output logic imask_out,
  output logic entry_ack_out
);
  logic [2:0] cnt_r;
  // mask comes up set after reset, set on entry, cleared by return or wait
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      imask_out <= 1'h1;
    end else if (set_imask_in) begin
      imask_out <= 1'h1;
    end else if (clear_imask_in || unstack_in) begin
      imask_out <= 1'h0;
    end
  end
  // stacking takes a variable time; the high index register is never pushed
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !int_start_in || entry_ack_out) begin
      cnt_r <= 3'h0;
      entry_ack_out <= 1'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      entry_ack_out <= (cnt_r == {1'h0, ack_dly_in});
    end
  end
endmodule : ewc_cpu_model
`default_nettype wire

// ===== ewc_exc_ctrl.sv
// exception, wait-mode and break-status controller with apb registers
`timescale 1ns/1ps
`default_nettype none
module ewc_exc_ctrl
  import ewc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // cpu side
  input wire logic instr_done_in,
  input wire logic imask_in,
  input wire logic swi_exec_in,
  input wire logic rti_exec_in,
  input wire logic wait_exec_in,
  input wire logic entry_ack_in,
  output logic int_start_out,
  output logic [3:0] vector_sel_out,
  output logic stack_pc_minus1_out,
  output logic stack_regs_out,
  output logic stack_high_index_out,
  output logic set_imask_out,
  output logic clear_imask_out,
  output logic unstack_regs_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  // interrupt sources
  input wire logic [N_IRQ-1:0] irq_req_in,
  input wire logic [N_IRQ-1:0] irq_en_in,
  // break and flag protection
  input wire logic break_in,
  input wire logic [N_FLAG-1:0] flag_step1_in,
  input wire logic [N_FLAG-1:0] flag_step2_in,
  output logic [N_FLAG-1:0] flag_clear_out,
  // reset sources and watchdog
  input wire logic por_in,
  input wire logic ext_rst_n_in,
  input wire logic wdog_rst_in,
  input wire logic ill_op_in,
  input wire logic ill_addr_in,
  input wire logic low_v_in,
  input wire logic watchdog_disable_bit_in,
  output logic int_rst_out,
  output logic watchdog_run_out
);

  // priority pick: lowest index wins
  function automatic logic [3:0] pick_irq(input logic [N_IRQ-1:0] req);
    logic [3:0] idx;
    idx = VEC_NONE;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pick_irq

  ewc_state_e state_r;
  ewc_state_e state_nxt;
  logic [3:0] vec_r;
  logic pcm1_r;
  logic [N_RST-1:0] rst_raw;
  logic [N_RST-1:0] rst_s1_r;
  logic [N_RST-1:0] rst_s2_r;
  logic any_rst;
  logic [7:0] break_status_r;
  logic [7:0] reset_cause_r;
  logic [7:0] break_flag_control_r;
  logic [N_FLAG-1:0] armed_r;
  logic [N_IRQ-1:0] live_req;
  logic wake_hit;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [3:0] wake_cnt_r;

  // reset sources come from outside the clock domain: two flip-flops each
  assign rst_raw = {low_v_in, ill_addr_in, ill_op_in, wdog_rst_in, ~ext_rst_n_in, por_in};
  genvar g;
  generate
    for (g = 0; g < N_RST; g++) begin : g_rst_sync
      always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
          rst_s1_r[g] <= 1'b0;
          rst_s2_r[g] <= 1'b0;
        end else begin
          rst_s1_r[g] <= rst_raw[g];
          rst_s2_r[g] <= rst_s1_r[g];
        end
      end
    end
  endgenerate

  // every source forces the internal reset directly, never arbitrated
  assign any_rst = |rst_s2_r;
  assign int_rst_out = any_rst;

  // enabled requests visible to arbitration
  assign live_req = irq_req_in & irq_en_in;
  assign wake_hit = |live_req;

  // exception sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (instr_done_in) begin
          if (swi_exec_in) begin
            state_nxt = ST_ENTRY;
          end else if (!imask_in && wake_hit) begin
            state_nxt = ST_ENTRY;
          end else if (wait_exec_in) begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (break_in) begin
          state_nxt = ST_RUN;
        end else if (wake_hit) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_cnt_r == 4'(WAKE_CYCLES - 1)) begin
          state_nxt = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (entry_ack_in) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // state register; any reset source overrides everything
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake delay counter
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst || state_r != ST_WAKE) begin
      wake_cnt_r <= 4'h0;
    end else begin
      wake_cnt_r <= wake_cnt_r + 4'h1;
    end
  end

  // latch the winner on entry; held untouched until acknowledged
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      vec_r <= VEC_NONE;
      pcm1_r <= 1'b0;
    end else if (state_r != ST_ENTRY && state_nxt == ST_ENTRY) begin
      if (state_r == ST_RUN && swi_exec_in) begin
        vec_r <= VEC_SWI;
        pcm1_r <= 1'b0;
      end else begin
        vec_r <= pick_irq(live_req);
        pcm1_r <= 1'b1;
      end
    end
  end

  // cpu handshake outputs
  assign int_start_out = (state_r == ST_ENTRY);
  assign vector_sel_out = vec_r;
  assign stack_pc_minus1_out = pcm1_r;
  assign stack_regs_out = (state_r == ST_ENTRY);
  assign stack_high_index_out = 1'b0;
  assign set_imask_out = (state_r == ST_ENTRY) && entry_ack_in;
  assign unstack_regs_out = (state_r == ST_RUN) && rti_exec_in && instr_done_in;
  assign clear_imask_out = (state_r == ST_RUN) && (state_nxt == ST_WAIT);
  assign cpu_clk_en_out = (state_r != ST_WAIT) && !any_rst;
  assign periph_clk_en_out = 1'b1;
  assign watchdog_run_out = !watchdog_disable_bit_in;

  // apb decode
  assign apb_setup = psel_in && !penable_in;
  assign apb_access = psel_in && penable_in;
  assign apb_wr = apb_access && pwrite_in && addr_ok;
  assign apb_rd = apb_access && !pwrite_in && addr_ok;
  assign addr_ok = (paddr_in == OFS_BREAK_STATUS) || (paddr_in == OFS_RESET_CAUSE) ||
                   (paddr_in == OFS_BREAK_FLAG_CONTROL);
  assign pready_out = apb_access;

  // read data and error taken in the setup cycle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (apb_setup) begin
      pslverr_out <= !addr_ok;
      case (paddr_in)
        OFS_BREAK_STATUS: prdata_out <= {24'h0, break_status_r};
        OFS_RESET_CAUSE: prdata_out <= {24'h0, reset_cause_r};
        OFS_BREAK_FLAG_CONTROL: prdata_out <= {24'h0, break_flag_control_r};
        default: prdata_out <= 32'h0;
      endcase
    end
  end

  // wait exit flag: set by break in wait, cleared by writing zero or any reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      break_status_r <= RST_BREAK_STATUS;
    end else if (state_r == ST_WAIT && break_in) begin
      break_status_r[BIT_WAIT_EXIT] <= 1'b1;
    end else if (apb_wr && paddr_in == OFS_BREAK_STATUS && !pwdata_in[BIT_WAIT_EXIT]) begin
      break_status_r[BIT_WAIT_EXIT] <= 1'b0;
    end
  end

  // break clear enable register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      break_flag_control_r <= RST_BREAK_FLAG_CONTROL;
    end else if (apb_wr && paddr_in == OFS_BREAK_FLAG_CONTROL) begin
      break_flag_control_r <= {7'h0, pwdata_in[BIT_CLEAR_ENABLE]};
    end
  end

  // reset cause: power on sets only its flag, others accumulate, read clears
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reset_cause_r <= RST_RESET_CAUSE;
    end else if (rst_s2_r[BIT_POR]) begin
      reset_cause_r <= RST_RESET_CAUSE;
    end else if (any_rst) begin
      reset_cause_r <= reset_cause_r | {2'h0, rst_s2_r};
    end else if (apb_rd && paddr_in == OFS_RESET_CAUSE) begin
      reset_cause_r <= 8'h00;
    end
  end

  // first step of two-step clears is remembered across break
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      armed_r <= '0;
    end else begin
      armed_r <= (armed_r | flag_step1_in) & ~flag_clear_out;
    end
  end

  // clear strobes to peripherals, blocked in break unless enabled
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_rst) begin
      flag_clear_out <= '0;
    end else if (break_in && !break_flag_control_r[BIT_CLEAR_ENABLE]) begin
      flag_clear_out <= '0;
    end else begin
      flag_clear_out <= flag_step2_in & (armed_r | flag_step1_in);
    end
  end

  // checks
  a_wake_then_stack: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_WAIT && !break_in && wake_hit) |=> ##1 int_start_out)
    else $error("stacking did not start one cycle after wake");
  a_swi_ignores_mask: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && swi_exec_in) |=>
    (int_start_out && vector_sel_out == VEC_SWI && !stack_pc_minus1_out))
    else $error("software interrupt not entered");
  a_mask_blocks_hw: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && !swi_exec_in && imask_in) |=> !int_start_out)
    else $error("hardware entry while masked");
  a_no_mid_instr: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && !instr_done_in) |=> !int_start_out)
    else $error("entry before instruction end");
  a_vector_held: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (int_start_out && !entry_ack_in) |=> $stable(vector_sel_out))
    else $error("latched vector changed");
  a_prio_pick: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && !swi_exec_in && !imask_in && live_req[0]) |=>
    (vector_sel_out == 4'h0 && stack_pc_minus1_out))
    else $error("highest priority request not chosen");
  a_reset_wins: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    any_rst |=> (state_r == ST_RUN && !int_start_out))
    else $error("reset did not override exception");
  a_break_protect: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (break_in && !break_flag_control_r[BIT_CLEAR_ENABLE]) |=> flag_clear_out == '0)
    else $error("flag cleared in protected break");
  a_wait_exit_set: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_WAIT && break_in) |=> break_status_r[BIT_WAIT_EXIT])
    else $error("break wait exit flag not set");
  a_cause_rd_clr: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (apb_rd && paddr_in == OFS_RESET_CAUSE) |=> reset_cause_r == 8'h00)
    else $error("reset cause not cleared by read");

  // return at a boundary must pull the stacked registers back
  a_rti_unstack: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && rti_exec_in) |-> unstack_regs_out)
    else $error("return did not unstack registers");

  // the mask is raised in the very cycle the cpu finishes stacking
  a_entry_sets_mask: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (int_start_out && entry_ack_in) |-> set_imask_out)
    else $error("entry did not set the mask");

  // wait with nothing to serve stops the cpu clock on the next cycle
  a_wait_stops_cpu: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && !swi_exec_in && (imask_in || !wake_hit) &&
     wait_exec_in) |=> (state_r == ST_WAIT && !cpu_clk_en_out))
    else $error("wait did not stop the cpu clock");

  // wait entry also drops the global mask so a wake can be taken
  a_wait_clr_mask: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && !swi_exec_in && (imask_in || !wake_hit) &&
     wait_exec_in) |-> clear_imask_out)
    else $error("wait did not clear the mask");

  // break leaves wait straight back to run
  a_break_exits_wait: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_WAIT && break_in) |=> state_r == ST_RUN)
    else $error("break did not end wait");

  // unmasked enabled request at a boundary enters with pc minus one
  a_hw_entry_pc: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (state_r == ST_RUN && instr_done_in && !swi_exec_in && !imask_in && wake_hit) |=>
    (int_start_out && stack_pc_minus1_out && vector_sel_out < 4'h8))
    else $error("hardware entry malformed");

  // any reset source wipes the wait exit flag
  a_status_rst_clr: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    any_rst |=> !break_status_r[BIT_WAIT_EXIT])
    else $error("reset left wait exit flag set");

  // a zero written to the flag clears it unless a new set arrives
  a_status_wr_clr: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (apb_wr && paddr_in == OFS_BREAK_STATUS && !pwdata_in[BIT_WAIT_EXIT] &&
     !(state_r == ST_WAIT && break_in)) |=> !break_status_r[BIT_WAIT_EXIT])
    else $error("writing zero did not clear wait exit flag");

  // power on leaves only its own cause flag
  a_por_cause: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    rst_s2_r[BIT_POR] |=> reset_cause_r == RST_RESET_CAUSE)
    else $error("power on cause not exclusive");

  // without power on, every active source is recorded in the cause register
  a_cause_records: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (any_rst && !rst_s2_r[BIT_POR]) |=>
    (reset_cause_r & {2'h0, $past(rst_s2_r)}) == {2'h0, $past(rst_s2_r)})
    else $error("reset source not recorded");

  // a second step outside break completes an armed clear
  a_second_step: assert property (@(posedge sys_clk_in) disable iff (srst_in || any_rst)
    (!break_in && flag_step2_in[0] && armed_r[0]) |=> flag_clear_out[0])
    else $error("second step did not clear flag");

  // reset sources stop the cpu clock while they stand
  a_rst_stops_cpu: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    any_rst |-> !cpu_clk_en_out)
    else $error("cpu clock ran during reset");

endmodule : ewc_exc_ctrl
`default_nettype wire

// ===== ewc_pkg.sv
// constants and types for the exception, wait and status control block
package ewc_pkg;
  localparam int N_IRQ = 8;
  localparam int N_FLAG = 8;
  localparam int N_RST = 6;
  // register byte offsets
  localparam logic [7:0] OFS_BREAK_STATUS = 8'h00;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h04;
  localparam logic [7:0] OFS_BREAK_FLAG_CONTROL = 8'h08;
  // field positions
  localparam int BIT_WAIT_EXIT = 1;
  localparam int BIT_CLEAR_ENABLE = 0;
  localparam int BIT_POR = 0;
  localparam int BIT_PIN = 1;
  localparam int BIT_WDOG = 2;
  localparam int BIT_ILL_OP = 3;
  localparam int BIT_ILL_ADDR = 4;
  localparam int BIT_LOW_V = 5;
  // values after reset
  localparam logic [7:0] RST_BREAK_STATUS = 8'h00;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h01;
  localparam logic [7:0] RST_BREAK_FLAG_CONTROL = 8'h00;
  // vector codes
  localparam logic [3:0] VEC_SWI = 4'h8;
  localparam logic [3:0] VEC_NONE = 4'hf;
  // cycles from wait exit decision to stacking
  localparam int WAKE_CYCLES = 1;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_WAKE = 2'b11,
    ST_ENTRY = 2'b10
  } ewc_state_e;
endpackage : ewc_pkg

// ===== tb_top.sv
// self-checking bench for the exception, wait and status controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ewc_pkg::*;
  logic sys_clk_in = 1'h0, srst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic instr_done_in = 1'h0, swi_exec_in = 1'h0, rti_exec_in = 1'h0, wait_exec_in = 1'h0;
  logic break_in = 1'h0, watchdog_disable_bit_in = 1'h0, start_d = 1'h0;
  logic [7:0] paddr_in = 8'h00, irq_req_in = 8'h00, irq_en_in = 8'hff, lfsr = 8'h41;
  logic [7:0] flag_step1_in = 8'h00, flag_step2_in = 8'h00, flag_clear_out;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic [5:0] rsrc = 6'h00;
  logic [3:0] vector_sel_out;
  logic [2:0] idx;
  logic [1:0] ack_dly_in = 2'h0;
  logic pready_out, pslverr_out, imask_in, entry_ack_in, int_start_out, stack_pc_minus1_out;
  logic stack_regs_out, stack_high_index_out, set_imask_out, clear_imask_out, unstack_regs_out;
  logic cpu_clk_en_out, periph_clk_en_out, int_rst_out, watchdog_run_out, ext_rst_n_in;
  logic por_in, wdog_rst_in, ill_op_in, ill_addr_in, low_v_in;
  logic [32:0] rd_q[$];
  logic [4:0] vec_q[$];
  int failures = 0, checks = 0;
  assign {low_v_in, ill_addr_in, ill_op_in, wdog_rst_in, por_in} = {rsrc[5:2], rsrc[0]};
  assign ext_rst_n_in = !rsrc[1];
  ewc_exc_ctrl dut (.sys_clk_in, .srst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .instr_done_in, .imask_in,
    .swi_exec_in, .rti_exec_in, .wait_exec_in, .entry_ack_in, .int_start_out, .vector_sel_out,
    .stack_pc_minus1_out, .stack_regs_out, .stack_high_index_out, .set_imask_out,
    .clear_imask_out, .unstack_regs_out, .cpu_clk_en_out, .periph_clk_en_out, .irq_req_in,
    .irq_en_in, .break_in, .flag_step1_in, .flag_step2_in, .flag_clear_out, .por_in,
    .ext_rst_n_in, .wdog_rst_in, .ill_op_in, .ill_addr_in, .low_v_in,
    .watchdog_disable_bit_in, .int_rst_out, .watchdog_run_out);
  ewc_cpu_model cpu (.sys_clk_in(sys_clk_in), .srst_in(srst_in || int_rst_out),
    .int_start_in(int_start_out), .set_imask_in(set_imask_out), .ack_dly_in(ack_dly_in),
    .clear_imask_in(clear_imask_out), .unstack_in(unstack_regs_out), .imask_out(imask_in),
    .entry_ack_out(entry_ack_in));
  // clock at 25 mhz
  always #20 sys_clk_in = !sys_clk_in;
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // one apb transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    if (!w) rd_q.push_back(e);
    @(posedge sys_clk_in);
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    psel_in <= 1'h1;
    @(posedge sys_clk_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    if (n >= 20) failures++;
    if (n >= 20) complete_run();
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb
  // one instruction boundary of the given kind
  task automatic bnd(input logic s, input logic r, input logic wt);
    @(posedge sys_clk_in);
    instr_done_in <= 1'h1;
    swi_exec_in <= s;
    rti_exec_in <= r;
    wait_exec_in <= wt;
    @(posedge sys_clk_in);
    instr_done_in <= 1'h0;
  endtask : bnd
  // wait for an entry to start and to be acknowledged
  task automatic serve;
    int n;
    n = 0;
    while (int_start_out !== 1'h1 && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (int_start_out === 1'h1 && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 40) failures++;
    if (n >= 40) complete_run();
  endtask : serve
  task automatic flag(input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] e);
    @(posedge sys_clk_in);
    flag_step1_in <= s1;
    flag_step2_in <= s2;
    @(posedge sys_clk_in);
    flag_step1_in <= 8'h00;
    flag_step2_in <= 8'h00;
    #1 chk({25'h0, e}, {25'h0, flag_clear_out});
  endtask : flag
  // results are taken off the queues as they appear at the outputs
  always @(posedge sys_clk_in) begin
    start_d <= int_start_out;
    if (psel_in && penable_in && pready_out === 1'h1 && !pwrite_in) begin
      if (rd_q.size() > 0) chk(rd_q.pop_front(), {pslverr_out, prdata_out});
      else failures++;
    end
    if (int_start_out === 1'h1 && start_d !== 1'h1) begin
      if (vec_q.size() > 0) chk({28'h0, vec_q.pop_front()}, {28'h0, stack_pc_minus1_out,
                                vector_sel_out});
      else failures++;
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 1'h0;
    apb(OFS_BREAK_STATUS, 1'h0, 32'h0, {25'h0, RST_BREAK_STATUS});
    apb(OFS_RESET_CAUSE, 1'h0, 32'h0, {25'h0, RST_RESET_CAUSE});
    apb(OFS_RESET_CAUSE, 1'h0, 32'h0, 33'h0);
    apb(OFS_BREAK_FLAG_CONTROL, 1'h0, 32'h0, {25'h0, RST_BREAK_FLAG_CONTROL});
    apb(8'h0c, 1'h0, 32'h0, {1'h1, 32'h0});
    $display("test registers done");
    bnd(1'h0, 1'h1, 1'h0);
    idx = lfsr[2:0];
    lfsr = lfsr_next(lfsr);
    ack_dly_in <= lfsr[1:0];
    irq_req_in <= 8'h01 << idx;
    vec_q.push_back({2'h2, idx});
    repeat (3) @(posedge sys_clk_in);
    #1 chk(33'h0, {32'h0, int_start_out});
    bnd(1'h0, 1'h0, 1'h0);
    serve();
    bnd(1'h0, 1'h0, 1'h0);
    repeat (3) @(posedge sys_clk_in);
    #1 chk(33'h0, {32'h0, int_start_out});
    irq_req_in <= 8'h22;
    irq_en_in <= 8'hfd;
    ack_dly_in <= 2'h3;
    vec_q.push_back(5'h15);
    bnd(1'h0, 1'h1, 1'h0);
    bnd(1'h0, 1'h0, 1'h0);
    @(posedge sys_clk_in);
    irq_req_in <= 8'h23;
    @(posedge sys_clk_in);
    #1 chk(33'h5, {29'h0, vector_sel_out});
    serve();
    vec_q.push_back(5'h10);
    bnd(1'h0, 1'h1, 1'h0);
    bnd(1'h0, 1'h0, 1'h0);
    serve();
    irq_req_in <= 8'h00;
    vec_q.push_back({1'h0, VEC_SWI});
    bnd(1'h1, 1'h0, 1'h0);
    serve();
    $display("test interrupts done");
    bnd(1'h0, 1'h0, 1'h1);
    #1 chk(33'h2, {31'h0, periph_clk_en_out, cpu_clk_en_out | imask_in});
    @(posedge sys_clk_in);
    irq_req_in <= 8'h04;
    vec_q.push_back(5'h12);
    @(posedge sys_clk_in);
    #1 chk(33'h0, {32'h0, int_start_out});
    @(posedge sys_clk_in);
    #1 chk(33'h1, {32'h0, int_start_out});
    serve();
    irq_req_in <= 8'h00;
    bnd(1'h0, 1'h0, 1'h1);
    @(posedge sys_clk_in);
    break_in <= 1'h1;
    repeat (2) @(posedge sys_clk_in);
    #1 chk(33'h1, {32'h0, cpu_clk_en_out});
    apb(OFS_BREAK_STATUS, 1'h0, 32'h0, 33'h2);
    apb(OFS_BREAK_STATUS, 1'h1, 32'h0, 33'h0);
    apb(OFS_BREAK_STATUS, 1'h0, 32'h0, 33'h0);
    $display("test wait done");
    apb(OFS_BREAK_FLAG_CONTROL, 1'h1, 32'h0, 33'h0);
    @(posedge sys_clk_in);
    break_in <= 1'h0;
    flag(8'h01, 8'h00, 8'h00);
    @(posedge sys_clk_in);
    break_in <= 1'h1;
    flag(8'h00, 8'h01, 8'h00);
    @(posedge sys_clk_in);
    break_in <= 1'h0;
    flag(8'h00, 8'h01, 8'h01);
    apb(OFS_BREAK_FLAG_CONTROL, 1'h1, {24'h0, lfsr[7:1], 1'h1}, 33'h0);
    @(posedge sys_clk_in);
    break_in <= 1'h1;
    flag(8'h02, 8'h02, 8'h02);
    @(posedge sys_clk_in);
    break_in <= 1'h0;
    $display("test flags done");
    for (int i = 0; i < N_RST; i++) begin
      @(posedge sys_clk_in);
      rsrc <= 6'h01 << i;
      repeat (4) @(posedge sys_clk_in);
      #1 chk(33'h1, {32'h0, int_rst_out & !cpu_clk_en_out});
      @(posedge sys_clk_in);
      rsrc <= 6'h00;
      repeat (6) @(posedge sys_clk_in);
      apb(OFS_RESET_CAUSE, 1'h0, 32'h0, {25'h0, 8'h01 << i});
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk_in);
      watchdog_disable_bit_in <= j[0];
      @(posedge sys_clk_in);
      chk({32'h0, !j[0]}, {32'h0, watchdog_run_out});
    end
    $display("test resets done");
    repeat (2) @(posedge sys_clk_in);
    if (rd_q.size() != 0 || vec_q.size() != 0) failures++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
